// File: rtl/mcsr_params.svh
// Offsets, field positions, reset values and timing figures of the monitor register bank.
`ifndef MCSR_PARAMS_SVH
`define MCSR_PARAMS_SVH
`define MCSR_ADDR_STEP14 7'h1e
`define MCSR_ADDR_STEP15 7'h1f
`define MCSR_ADDR_MONCFG 7'h40
`define MCSR_ADDR_MAP_LAST 7'h59
`define MCSR_RESULT_RESET 16'h0000
`define MCSR_MONCFG_RESET 16'h0000
`define MCSR_MONCFG_WMASK 16'hf107
`define MCSR_READ_IDLE 16'h0000
`define MCSR_POLY_CCITT 16'h1021
`define MCSR_POLY_ANSI 16'h8005
`define MCSR_CRC_INIT 16'hffff
`define MCSR_CLK_KHZ 200000
`define MCSR_OSC_KHZ 8192
`define MCSR_TIMEOUT_EXP 14
`define MCSR_HOST_WIN1 5120
`define MCSR_HOST_WIN2 10240
`define MCSR_HOST_WIN3 20480
`define MCSR_CMD_LAST_BIT 6'd15
`define MCSR_DATA_LAST_BIT 6'd31
`define MCSR_CRC_LAST_BIT 6'd47
`endif

// File: rtl/mcsr_pkg.sv
// Types shared by the monitor register bank.
package mcsr_pkg;
  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] pad;
  } mcsr_cmd_t;
  typedef struct packed {
    logic map_section_one_crc_enable;
    logic crc_poly_ansi;
    logic sclk_count_enable;
    logic timeout_enable;
    logic [2:0] rsvd_hi;
    logic fault_output_polarity;
    logic [4:0] rsvd_lo;
    logic host_loss_output_polarity;
    logic [1:0] host_loss_window_select;
  } mcsr_cfg_t;
  typedef enum logic [4:0] {
    MCSR_IDLE = 5'b00001,
    MCSR_CMD = 5'b00010,
    MCSR_DATA = 5'b00100,
    MCSR_CHECK = 5'b01000,
    MCSR_IGNORE = 5'b10000
  } mcsr_state_t;
endpackage

// File: rtl/mcsr_crc16.sv
// Serial 16-bit CRC engine with selectable polynomial.
`timescale 1ns/1ps
`include "mcsr_params.svh"
module mcsr_crc16 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic init,
  input wire logic bit_en,
  input wire logic bit_in,
  input wire logic poly_ansi,
  output logic [15:0] crc
);
  wire logic feedback = crc[15] ^ bit_in;
  wire logic [15:0] poly = poly_ansi ? `MCSR_POLY_ANSI : `MCSR_POLY_CCITT;
  wire logic [15:0] crc_next = {crc[14:0], 1'b0} ^ (feedback ? poly : 16'h0000);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc <= `MCSR_CRC_INIT;
    end else if (init) begin
      crc <= `MCSR_CRC_INIT;
    end else if (bit_en) begin
      crc <= crc_next;
    end
  end
endmodule

// File: rtl/mcsr_top.sv
// Monitor configuration and sequencer result registers behind a serial port.
// Contract
// - Step 14 result reads back, resets zero.
// - Step 15 result at 1Fh, resets zero.
// - Bit 15 enables map CRC over 40h-59h.
// - Bit 14 picks CCITT or ANSI polynomial.
// - Bit 13 enables the clock edge counter.
// - Bit 12 checks frame ends within 2^14 ticks.
// - After timeout, remaining frame input is ignored.
// - New frame starts only at next select fall.
// - Reserved bits 11:9 read zero, ignore writes.
// - Bit 8 sets fault output polarity.
// - Host-loss watchdog windows from two-bit code.
`timescale 1ns/1ps
`include "mcsr_params.svh"
module mcsr_top #(
  parameter int TIMEOUT_TICKS = 1 << `MCSR_TIMEOUT_EXP,
  parameter int HOST_WIN1 = `MCSR_HOST_WIN1,
  parameter int HOST_WIN2 = `MCSR_HOST_WIN2,
  parameter int HOST_WIN3 = `MCSR_HOST_WIN3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic [15:0] seq_step14_in,
  input wire logic seq_step14_load,
  input wire logic [15:0] seq_step15_in,
  input wire logic seq_step15_load,
  output logic [6:0] map_addr,
  input wire logic [15:0] map_word_in,
  output logic [15:0] map_crc,
  output logic map_crc_valid,
  output logic [7:0] sclk_edge_count,
  output logic spi_timeout,
  input wire logic [7:0] fault_status,
  input wire logic [7:0] fault_mask,
  output logic fault_out,
  output logic host_loss_out
);
  localparam logic [4:0] MAP_LAST_IDX = 5'(`MCSR_ADDR_MAP_LAST - `MCSR_ADDR_MONCFG);
  localparam logic [14:0] TMO_LIMIT = 15'(TIMEOUT_TICKS);
  localparam logic [17:0] CLK_KHZ = 18'(`MCSR_CLK_KHZ);
  localparam logic [18:0] OSC_KHZ = 19'(`MCSR_OSC_KHZ);

  logic [2:0] cs_sync, sclk_sync, sdi_sync;
  mcsr_pkg::mcsr_state_t state_reg, state_next;
  logic [5:0] bit_cnt_reg;
  logic [15:0] shift_reg, data_reg, tx_reg, cfg_reg, step14_reg, step15_reg;
  mcsr_pkg::mcsr_cmd_t cmd_reg;
  logic sdo_reg, commit_reg, timeout_reg;
  logic [14:0] tmo_cnt_reg, wd_cnt_reg;
  logic [17:0] osc_acc_reg;
  logic [7:0] sclk_cnt_reg;
  logic host_lost_reg, fault_reg;
  logic [4:0] map_idx_reg;
  logic [3:0] map_bit_reg;
  logic map_wrap_reg;
  logic [15:0] map_crc_reg;
  logic map_valid_reg;
  logic [15:0] frame_crc, map_crc_run;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_sync <= 3'h7;
      sclk_sync <= 3'h0;
      sdi_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      sdi_sync <= {sdi_sync[1:0], sdi};
    end
  end

  wire logic cs_fall = cs_sync[2] & ~cs_sync[1];
  wire logic cs_rise = ~cs_sync[2] & cs_sync[1];
  wire logic sclk_rise = ~sclk_sync[2] & sclk_sync[1];
  wire logic sclk_fall = sclk_sync[2] & ~sclk_sync[1];
  wire logic sdi_bit = sdi_sync[1];
  wire mcsr_pkg::mcsr_cfg_t cfg = mcsr_pkg::mcsr_cfg_t'(cfg_reg);
  wire logic receiving = (state_reg == mcsr_pkg::MCSR_CMD) | (state_reg == mcsr_pkg::MCSR_DATA)
                         | (state_reg == mcsr_pkg::MCSR_CHECK);
  wire logic take_bit = receiving & sclk_rise;
  wire logic [15:0] word_in = {shift_reg[14:0], sdi_bit};
  wire mcsr_pkg::mcsr_cmd_t cmd_in = mcsr_pkg::mcsr_cmd_t'(word_in);
  wire logic tmo_hit = cfg.timeout_enable & receiving & (tmo_cnt_reg == TMO_LIMIT);

  wire logic [18:0] osc_sum = {1'b0, osc_acc_reg} + OSC_KHZ;
  wire logic osc_tick = osc_sum >= {1'b0, CLK_KHZ};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_acc_reg <= 18'h00000;
    end else begin
      osc_acc_reg <= osc_tick ? 18'(osc_sum - {1'b0, CLK_KHZ}) : osc_sum[17:0];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcsr_pkg::MCSR_IDLE: begin
        if (cs_fall) begin
          state_next = mcsr_pkg::MCSR_CMD;
        end
      end
      mcsr_pkg::MCSR_CMD, mcsr_pkg::MCSR_DATA, mcsr_pkg::MCSR_CHECK: begin
        if (cs_rise) begin
          state_next = mcsr_pkg::MCSR_IDLE;
        end else if (tmo_hit) begin
          state_next = mcsr_pkg::MCSR_IGNORE;
        end else if (take_bit && bit_cnt_reg == `MCSR_CMD_LAST_BIT) begin
          state_next = mcsr_pkg::MCSR_DATA;
        end else if (take_bit && bit_cnt_reg == `MCSR_DATA_LAST_BIT) begin
          state_next = mcsr_pkg::MCSR_CHECK;
        end else if (take_bit && bit_cnt_reg == `MCSR_CRC_LAST_BIT) begin
          state_next = mcsr_pkg::MCSR_IGNORE;
        end
      end
      mcsr_pkg::MCSR_IGNORE: begin
        if (cs_rise) begin
          state_next = mcsr_pkg::MCSR_IDLE;
        end
      end
      default: begin
        state_next = mcsr_pkg::MCSR_IDLE;
      end
    endcase
  end

  wire logic [15:0] read_word = (cmd_in.addr == `MCSR_ADDR_STEP14) ? step14_reg
                              : (cmd_in.addr == `MCSR_ADDR_STEP15) ? step15_reg
                              : (cmd_in.addr == `MCSR_ADDR_MONCFG) ? cfg_reg
                              : `MCSR_READ_IDLE;
  wire logic crc_good = take_bit && bit_cnt_reg == `MCSR_CRC_LAST_BIT && word_in == frame_crc;
  wire logic cfg_write = commit_reg & cmd_reg.write & (cmd_reg.addr == `MCSR_ADDR_MONCFG);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= mcsr_pkg::MCSR_IDLE;
      bit_cnt_reg <= 6'h00;
      shift_reg <= 16'h0000;
      cmd_reg <= '0;
      data_reg <= 16'h0000;
      commit_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      commit_reg <= crc_good;
      timeout_reg <= tmo_hit & ~cs_rise;
      if (cs_fall) begin
        bit_cnt_reg <= 6'h00;
      end else if (take_bit) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        shift_reg <= word_in;
        if (bit_cnt_reg == `MCSR_CMD_LAST_BIT) begin
          cmd_reg <= cmd_in;
        end
        if (bit_cnt_reg == `MCSR_DATA_LAST_BIT) begin
          data_reg <= word_in;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_reg <= 16'h0000;
      sdo_reg <= 1'b0;
    end else if (take_bit && bit_cnt_reg == `MCSR_CMD_LAST_BIT) begin
      tx_reg <= read_word;
    end else if (sclk_fall && state_reg == mcsr_pkg::MCSR_DATA) begin
      sdo_reg <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= `MCSR_MONCFG_RESET;
      step14_reg <= `MCSR_RESULT_RESET;
      step15_reg <= `MCSR_RESULT_RESET;
    end else begin
      if (cfg_write) begin
        cfg_reg <= (cfg_reg & ~`MCSR_MONCFG_WMASK) | (data_reg & `MCSR_MONCFG_WMASK);
      end
      if (seq_step14_load) begin
        step14_reg <= seq_step14_in;
      end
      if (seq_step15_load) begin
        step15_reg <= seq_step15_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt_reg <= 15'h0000;
      sclk_cnt_reg <= 8'h00;
    end else begin
      if (cs_fall) begin
        tmo_cnt_reg <= 15'h0000;
      end else if (receiving && osc_tick && tmo_cnt_reg != TMO_LIMIT && !cs_rise) begin
        tmo_cnt_reg <= tmo_cnt_reg + 15'h0001;
      end
      if (cs_fall) begin
        sclk_cnt_reg <= 8'h00;
      end else if (cfg.sclk_count_enable && sclk_rise && state_reg != mcsr_pkg::MCSR_IDLE) begin
        sclk_cnt_reg <= sclk_cnt_reg + 8'h01;
      end
    end
  end

  mcsr_crc16 u_frame_crc (
    .clk(clk),
    .rstn(rstn),
    .init(cs_fall),
    .bit_en(take_bit && bit_cnt_reg <= `MCSR_DATA_LAST_BIT),
    .bit_in(sdi_bit),
    .poly_ansi(cfg.crc_poly_ansi),
    .crc(frame_crc)
  );

  wire logic [14:0] wd_limit = (cfg.host_loss_window_select == 2'b01) ? 15'(HOST_WIN1)
                             : (cfg.host_loss_window_select == 2'b10) ? 15'(HOST_WIN2)
                             : 15'(HOST_WIN3);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_reg <= 15'h0000;
      host_lost_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= |(fault_status & ~fault_mask);
      if (cfg.host_loss_window_select == 2'b00) begin
        wd_cnt_reg <= 15'h0000;
        host_lost_reg <= 1'b0;
      end else if (commit_reg) begin
        wd_cnt_reg <= 15'h0000;
      end else if (osc_tick && !host_lost_reg) begin
        if (wd_cnt_reg + 15'h0001 >= wd_limit) begin
          host_lost_reg <= 1'b1;
        end else begin
          wd_cnt_reg <= wd_cnt_reg + 15'h0001;
        end
      end
    end
  end

  wire logic [6:0] map_addr_cur = `MCSR_ADDR_MONCFG + {2'b00, map_idx_reg};
  wire logic [15:0] map_word = (map_addr_cur == `MCSR_ADDR_MONCFG) ? cfg_reg : map_word_in;
  wire logic map_last = (map_idx_reg == MAP_LAST_IDX) & (map_bit_reg == 4'hf);
  wire logic map_feed = cfg.map_section_one_crc_enable & ~map_wrap_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      map_idx_reg <= 5'h00;
      map_bit_reg <= 4'h0;
      map_wrap_reg <= 1'b0;
      map_crc_reg <= 16'h0000;
      map_valid_reg <= 1'b0;
    end else if (!cfg.map_section_one_crc_enable) begin
      map_idx_reg <= 5'h00;
      map_bit_reg <= 4'h0;
      map_wrap_reg <= 1'b0;
      map_crc_reg <= 16'h0000;
      map_valid_reg <= 1'b0;
    end else if (map_wrap_reg) begin
      map_wrap_reg <= 1'b0;
      map_crc_reg <= map_crc_run;
      map_valid_reg <= 1'b1;
    end else begin
      map_bit_reg <= map_bit_reg + 4'h1;
      if (map_bit_reg == 4'hf) begin
        map_idx_reg <= map_last ? 5'h00 : map_idx_reg + 5'h01;
      end
      map_wrap_reg <= map_last;
    end
  end

  mcsr_crc16 u_map_crc (
    .clk(clk),
    .rstn(rstn),
    .init(map_wrap_reg | ~cfg.map_section_one_crc_enable),
    .bit_en(map_feed),
    .bit_in(map_word[4'hf - map_bit_reg]),
    .poly_ansi(cfg.crc_poly_ansi),
    .crc(map_crc_run)
  );

  assign sdo = sdo_reg;
  assign sdo_oe = ~cs_sync[1];
  assign map_addr = map_addr_cur;
  assign map_crc = map_crc_reg;
  assign map_crc_valid = map_valid_reg;
  assign sclk_edge_count = sclk_cnt_reg;
  assign spi_timeout = timeout_reg;
  assign fault_out = cfg.fault_output_polarity ? fault_reg : ~fault_reg;
  assign host_loss_out = cfg.host_loss_output_polarity ? host_lost_reg : ~host_lost_reg;
endmodule

// File: testbench/mcsr_top_properties.sv
// Concurrent checks on the ports of the monitor register bank.
`timescale 1ns/1ps
module mcsr_top_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic spi_timeout,
  input wire logic [15:0] map_crc,
  input wire logic map_crc_valid,
  input wire logic [6:0] map_addr,
  input wire logic [7:0] fault_status,
  input wire logic [7:0] fault_mask,
  input wire logic fault_out,
  input wire logic [7:0] sclk_edge_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_frame_start;
    $fell(cs_n);
  endsequence
  sequence s_no_timeout;
    !spi_timeout [*8];
  endsequence
  property p_oe_idle;
    cs_n [*3] |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo_oe high while idle");
  property p_to_pulse;
    spi_timeout |=> s_no_timeout;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout repeated");
  property p_to_restart;
    s_frame_start |-> s_no_timeout;
  endproperty
  a_to_restart: assert property (p_to_restart) else $error("timeout right after fall");
  property p_crc_idle;
    !map_crc_valid |-> map_crc == 16'h0000;
  endproperty
  a_crc_idle: assert property (p_crc_idle) else $error("map crc without pass");
  property p_addr_range;
    map_crc_valid |-> map_addr >= 7'h40 && map_addr <= 7'h59;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("map address out of range");
  property p_fault_follow;
    $changed(|(fault_status & ~fault_mask)) |=> $changed(fault_out);
  endproperty
  a_fault_follow: assert property (p_fault_follow) else $error("fault pin stuck");
  property p_count_step;
    $changed(sclk_edge_count) |->
      sclk_edge_count == $past(sclk_edge_count) + 8'h01 || sclk_edge_count == 8'h00;
  endproperty
  a_count_step: assert property (p_count_step) else $error("edge count jumped");
  property p_count_idle;
    cs_n [*4] |=> $stable(sclk_edge_count);
  endproperty
  a_count_idle: assert property (p_count_idle) else $error("edge count moved idle");
endmodule

bind mcsr_top mcsr_top_properties u_props (.clk(clk), .rstn(rstn), .cs_n(cs_n),
  .sdo_oe(sdo_oe), .spi_timeout(spi_timeout), .map_crc(map_crc),
  .map_crc_valid(map_crc_valid), .map_addr(map_addr), .fault_status(fault_status),
  .fault_mask(fault_mask), .fault_out(fault_out), .sclk_edge_count(sclk_edge_count));

// File: testbench/mcsr_host.sv
// Host serial controller model that sends 48-bit frames to the register bank.
`timescale 1ns/1ps
module mcsr_host (
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // Sends a frame MSB first after holding select low for gap + 32 ns; returns the data word.
  task automatic xfer(input logic [47:0] f, input int gap, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    #(gap + 32);
    for (int i = 0; i < 48; i++) begin
      sclk = 1'b0;
      sdi = f[47 - i];
      #32;
      sclk = 1'b1;
      if (i > 15 && i < 32) rd[31 - i] = sdo;
      #32;
    end
    sclk = 1'b0;
    #32;
    cs_n = 1'b1;
    sdi = ~sdi;
    #96;
  endtask
endmodule

// File: testbench/mcsr_top_tb.sv
// Self-checking bench for the monitor register bank.
`timescale 1ns/1ps
`include "mcsr_params.svh"
module mcsr_top_tb;
  logic clk, rstn, cs_n, sclk, sdi, sdo, sdo_oe, s14_ld, s15_ld, ansi;
  logic map_crc_valid, spi_timeout, fault_out, host_loss_out;
  logic [15:0] s14, s15, map_crc, got;
  logic [6:0] map_addr;
  logic [7:0] cnt, f_st, f_mk;
  int bad_count, compares, cyc, to_cnt, base;
  wire logic [15:0] map_word = {9'h000, map_addr};
  mcsr_top #(.TIMEOUT_TICKS(64), .HOST_WIN1(8), .HOST_WIN2(16), .HOST_WIN3(32)) u_dut (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .seq_step14_in(s14), .seq_step14_load(s14_ld), .seq_step15_in(s15),
    .seq_step15_load(s15_ld), .map_addr(map_addr), .map_word_in(map_word),
    .map_crc(map_crc), .map_crc_valid(map_crc_valid), .sclk_edge_count(cnt),
    .spi_timeout(spi_timeout), .fault_status(f_st), .fault_mask(f_mk),
    .fault_out(fault_out), .host_loss_out(host_loss_out));
  mcsr_host u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (spi_timeout === 1'b1) to_cnt++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  function automatic logic [47:0] fr(input logic [15:0] cmd, input logic [15:0] d, input logic a);
    logic [15:0] c;
    logic [31:0] w;
    c = `MCSR_CRC_INIT;
    w = {cmd, d};
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((w[i] ^ c[15]) ? (a ? `MCSR_POLY_ANSI : `MCSR_POLY_CCITT) : 16'h0000);
    return {cmd, d, c};
  endfunction
  function automatic logic [15:0] mapcrc(input logic [15:0] w40, input logic a);
    logic [15:0] c;
    logic [15:0] w;
    logic [15:0] p;
    c = `MCSR_CRC_INIT;
    p = a ? `MCSR_POLY_ANSI : `MCSR_POLY_CCITT;
    for (int k = `MCSR_ADDR_MONCFG; k <= `MCSR_ADDR_MAP_LAST; k++) begin
      w = (k == `MCSR_ADDR_MONCFG) ? w40 : 16'(k);
      for (int i = 15; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((w[i] ^ c[15]) ? p : 16'h0000);
    end
    return c;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e, input int gap = 0);
    u_host.xfer(fr({1'b0, a, 8'h00}, 16'h0000, ansi), gap, got);
    tick(1);
    chk(got, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad = 1'b0,
                    input int gap = 0);
    u_host.xfer(fr({1'b1, a, 8'h00}, d, ansi ^ bad), gap, got);
    tick(1);
    if (!bad && gap == 0 && a == `MCSR_ADDR_MONCFG) ansi = d[14];
  endtask
  initial begin
    rstn = 1'b0;
    {s14, s15, s14_ld, s15_ld, f_st, f_mk, ansi} = '0;
    {bad_count, compares, cyc, to_cnt, base} = '0;
    tick(6);
    rstn = 1'b1;
    tick(3);
    chk({15'h0000, fault_out}, 16'h0001);
    chk({15'h0000, host_loss_out}, 16'h0001);
    rd(`MCSR_ADDR_STEP14, `MCSR_RESULT_RESET, 9000);
    chk(to_cnt[15:0], 16'h0000);
    rd(`MCSR_ADDR_STEP15, `MCSR_RESULT_RESET);
    rd(`MCSR_ADDR_MONCFG, `MCSR_MONCFG_RESET);
    chk({8'h00, cnt}, 16'h0000);
    s14 = 16'h8001;
    s15 = 16'h7ffe;
    {s14_ld, s15_ld} = 2'h3;
    tick(1);
    {s14_ld, s15_ld} = 2'h0;
    rd(`MCSR_ADDR_STEP14, 16'h8001);
    rd(`MCSR_ADDR_STEP15, 16'h7ffe);
    wr(`MCSR_ADDR_MONCFG, 16'hffff);
    rd(`MCSR_ADDR_MONCFG, 16'hf107);
    wr(`MCSR_ADDR_MONCFG, 16'h0000, 1'b1);
    rd(`MCSR_ADDR_MONCFG, 16'hf107);
    wr(`MCSR_ADDR_MONCFG, 16'h2000);
    rd(`MCSR_ADDR_MONCFG, 16'h2000);
    chk({8'h00, cnt}, 16'h0030);
    wr(`MCSR_ADDR_MONCFG, 16'h1000);
    base = to_cnt;
    rd(`MCSR_ADDR_MONCFG, 16'h1000, 3000);
    rd(`MCSR_ADDR_MONCFG, 16'h1000, 3000);
    chk(16'(to_cnt - base), 16'h0000);
    wr(`MCSR_ADDR_MONCFG, 16'h0004, 1'b0, 9000);
    chk(16'(to_cnt - base), 16'h0001);
    rd(`MCSR_ADDR_MONCFG, 16'h1000);
    wr(`MCSR_ADDR_MONCFG, 16'h8000);
    for (int i = 0; i < 1000 && map_crc_valid !== 1'b1; i++) tick(1);
    chk({15'h0000, map_crc_valid}, 16'h0001);
    chk(map_crc, mapcrc(16'h8000, 1'b0));
    wr(`MCSR_ADDR_MONCFG, 16'hc000);
    tick(850);
    chk(map_crc, mapcrc(16'hc000, 1'b1));
    wr(`MCSR_ADDR_MONCFG, 16'h0000);
    tick(2);
    chk(map_crc, 16'h0000);
    f_st = 8'h01;
    tick(3);
    chk({15'h0000, fault_out}, 16'h0000);
    f_mk = 8'h01;
    tick(3);
    chk({15'h0000, fault_out}, 16'h0001);
    wr(`MCSR_ADDR_MONCFG, 16'h0100);
    f_mk = 8'h00;
    tick(3);
    chk({15'h0000, fault_out}, 16'h0001);
    f_st = 8'h00;
    tick(3);
    chk({15'h0000, fault_out}, 16'h0000);
    for (int k = 1; k < 4; k++) begin
      wr(`MCSR_ADDR_MONCFG, 16'(k + 4 * (k / 3)));
      tick(120 << (k - 1));
      chk({15'h0000, host_loss_out}, {15'h0000, k != 3});
      tick(98 << (k - 1));
      chk({15'h0000, host_loss_out}, {15'h0000, k == 3});
      wr(`MCSR_ADDR_MONCFG, 16'h0000);
      chk({15'h0000, host_loss_out}, 16'h0001);
    end
    wrap_up();
  end
endmodule
